/* emac_ctrl.sv */
// External memory area controller: area decode, wait states, page ROM reads.
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "emac_regs.svh"
module emac_ctrl
  import emac_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  output logic             mem_ack,
  input  wire logic        wait_n,
  input  wire logic [1:0]  boot_width_pins,
  output logic      [3:0]  chip_sel_n,
  output logic      [1:0]  bus_width,
  output logic      [1:0]  mem_type,
  output logic             strobe_n,
  output logic             page_cycle
);

  // Registers of the four areas and the defaults.
  logic [7:0] wait_reg [4];
  logic [7:0] bcfg_reg [4];
  logic [7:0] mask_reg [4];
  logic [7:0] start_reg [4];
  logic [7:0] dwait_reg, dbus_reg, page_reg;
  logic       boot_load_reg;
  logic [1:0] boot_s1_reg, boot_s2_reg, boot_s3_reg;
  logic       ack_reg;
  logic [31:0] rdat_reg;
  emac_state_t state_reg, state_next;

  logic bus_hit;
  logic bus_wr;
  assign bus_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr  = bus_hit & wb_we_i & wb_sel_i[0];

  // Boot pins pass three flops; a value counts once the last two agree.
  // The last two stages reset to values that differ from each other, so the
  // reset contents are never taken for the strap setting.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_s1_reg <= 2'h3;
      boot_s2_reg <= 2'h0;
      boot_s3_reg <= 2'h3;
    end else begin
      boot_s1_reg <= boot_width_pins;
      boot_s2_reg <= boot_s1_reg;
      boot_s3_reg <= boot_s2_reg;
    end
  end

  logic wait_busy;
  // The memory drives wait in step with the bus states, so it is read
  // directly; a three-stage delay would miss a wait raised in state two.
  assign wait_busy = ~wait_n;

  // Register file per area; one generate loop carries the decode.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_area
      logic [7:0] wait_next, bcfg_next, mask_next, start_next;
      logic [7:0] base_ofs;
      assign base_ofs = 8'(g * 4);
      always_comb begin
        wait_next  = wait_reg[g];
        bcfg_next  = bcfg_reg[g];
        mask_next  = mask_reg[g];
        start_next = start_reg[g];
        if (g == 2 && boot_load_reg && boot_s2_reg == boot_s3_reg) begin
          bcfg_next[1:0] = boot_s3_reg;
        end
        if (bus_wr) begin
          if (wb_adr_i == base_ofs + `EMAC_OFS_A0_WAIT) begin
            wait_next = wb_dat_i[7:0] & 8'h77;
          end
          if (wb_adr_i == base_ofs + `EMAC_OFS_A0_BUS) begin
            bcfg_next = wb_dat_i[7:0] & ((g == 2) ? 8'hDF : 8'h9F);
            // Of the four areas, only area 1 keeps the SDRAM code.
            if (g != 1 && wb_dat_i[3:2] == `EMAC_MT_SDRAM) begin
              bcfg_next[3:2] = 2'h0;
            end
          end
          if (wb_adr_i == base_ofs + `EMAC_OFS_A0_MASK) begin
            mask_next = wb_dat_i[7:0];
          end
          if (wb_adr_i == base_ofs + `EMAC_OFS_A0_START) begin
            start_next = wb_dat_i[7:0];
          end
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          wait_reg[g]  <= `EMAC_WAIT_RST;
          bcfg_reg[g]  <= (g == 2) ? `EMAC_A2_BUS_RST
                                   : `EMAC_BUS_RST;
          mask_reg[g]  <= `EMAC_MASK_RST;
          start_reg[g] <= `EMAC_START_RST;
        end else begin
          wait_reg[g]  <= wait_next;
          bcfg_reg[g]  <= bcfg_next;
          mask_reg[g]  <= mask_next;
          start_reg[g] <= start_next;
        end
      end
    end
  endgenerate

  // Shared registers and bus answer; ack comes one cycle after the request.
  logic [7:0]  dwait_next, dbus_next, page_next;
  logic        boot_load_next;
  logic [31:0] rdat_next;
  logic [7:0]  rsel;
  always_comb begin
    dwait_next     = dwait_reg;
    dbus_next      = dbus_reg;
    page_next      = page_reg;
    boot_load_next = boot_load_reg;
    if (boot_load_reg && boot_s2_reg == boot_s3_reg) begin
      boot_load_next = 1'b0;
    end
    if (bus_wr && wb_adr_i == `EMAC_OFS_DEF_WAIT) begin
      dwait_next = wb_dat_i[7:0] & 8'h77;
    end
    if (bus_wr && wb_adr_i == `EMAC_OFS_DEF_BUS) begin
      dbus_next = wb_dat_i[7:0] & 8'h0F;
    end
    if (bus_wr && wb_adr_i == `EMAC_OFS_PAGE) begin
      page_next = wb_dat_i[7:0] & 8'h1F;
    end
    // Write-only settings read as zero; mask, start, page, status read back.
    rsel = 8'h00;
    if (wb_adr_i < 8'h10 && wb_adr_i[1]) begin
      rsel = wb_adr_i[0] ? start_reg[wb_adr_i[3:2]] : mask_reg[wb_adr_i[3:2]];
    end else if (wb_adr_i == `EMAC_OFS_PAGE) begin
      rsel = page_reg;
    end else if (wb_adr_i == `EMAC_OFS_STATUS) begin
      rsel = {3'h0, state_reg};
    end
    rdat_next = bus_hit ? {24'h0, rsel} : rdat_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dwait_reg     <= `EMAC_WAIT_RST;
      dbus_reg      <= `EMAC_BUS_RST;
      page_reg      <= `EMAC_PAGE_RST;
      boot_load_reg <= 1'b1;
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0;
    end else begin
      dwait_reg     <= dwait_next;
      dbus_reg      <= dbus_next;
      page_reg      <= page_next;
      boot_load_reg <= boot_load_next;
      ack_reg       <= bus_hit;
      rdat_reg      <= rdat_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // Area decode: compare unmasked bits of A23..A16 against the base; area 2 without the range bit hits whenever enabled.
  logic [3:0]  hit;
  logic [15:0] cmp_mask [4];
  always_comb begin
    cmp_mask[0] = {3'h0, mask_reg[0][7:2], {6{mask_reg[0][1]}},
                   mask_reg[0][0]};
    cmp_mask[1] = {2'h0, mask_reg[1][7:2], {7{mask_reg[1][1]}},
                   mask_reg[1][0]};
    cmp_mask[2] = {1'b0, mask_reg[2], 7'h7F};
    cmp_mask[3] = {1'b0, mask_reg[3], 7'h7F};
    for (int i = 0; i < 4; i++) begin
      // The base holds only A23..A16, so lower unmasked bits are not compared.
      hit[i] = bcfg_reg[i][`EMAC_BIT_ENABLE] &&
               (((mem_addr[23:8] ^ {start_reg[i], 8'h00}) & ~cmp_mask[i]
                 & 16'hFF00) == 16'h0000);
    end
    if (!bcfg_reg[2][`EMAC_BIT_RANGE]) begin
      hit[2] = bcfg_reg[2][`EMAC_BIT_ENABLE];
    end
  end

  // Lowest hit wins; index 4 is the default area.
  logic [2:0] area;
  logic [7:0] cur_wait, cur_bus;
  always_comb begin
    area = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (hit[i]) begin
        area = 3'(i);
      end
    end
    cur_wait = (area == 3'h4) ? dwait_reg : wait_reg[area[1:0]];
    cur_bus  = (area == 3'h4) ? dbus_reg : bcfg_reg[area[1:0]];
  end

  // Translate a wait code into total states; the pin code and unused codes give zero.
  function automatic logic [2:0] emac_states(input logic [2:0] code);
    case (code)
      `EMAC_WS_2: emac_states = 3'h2;
      `EMAC_WS_3: emac_states = 3'h3;
      `EMAC_WS_4: emac_states = 3'h4;
      `EMAC_WS_5: emac_states = 3'h5;
      `EMAC_WS_6: emac_states = 3'h6;
      default:    emac_states = 3'h0;
    endcase
  endfunction

  // Access sequencer.
  logic [2:0]  cnt_reg, cnt_next, len;
  logic [2:0]  last_area_reg, last_area_next;
  logic        pin_mode, page_ok, in_page_reg, in_page_next;
  logic [23:3] page_tag_reg, page_tag_next;
  logic [20:0] pmask;
  // The tag keeps A23..A3; the mask drops the offset bits inside a page.
  always_comb begin
    case (page_reg[1:0])
      2'h0: pmask = 21'h1FFFF8;
      2'h1: pmask = 21'h1FFFFC;
      2'h2: pmask = 21'h1FFFFE;
      default: pmask = 21'h1FFFFF;
    endcase
  end
  assign pin_mode = (mem_we ? cur_wait[6:4] : cur_wait[2:0]) == `EMAC_WS_PIN;
  // Page timing only for area-2 reads inside the page already opened.
  assign page_ok = page_reg[`EMAC_BIT_PG_EN] && area == 3'h2 && !mem_we &&
                   in_page_reg &&
                   ((mem_addr[23:3] & pmask) == (page_tag_reg & pmask));
  always_comb begin
    len = page_ok ? 3'(page_reg[3:2]) + 3'h1
                  : emac_states(mem_we ? cur_wait[6:4] : cur_wait[2:0]);
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    last_area_next = last_area_reg;
    in_page_next   = in_page_reg;
    page_tag_next  = page_tag_reg;
    case (state_reg)
      EMAC_IDLE: begin
        if (mem_req) begin
          cnt_next = 3'h1;
          if (area != last_area_reg && ((area == 3'h4) ? 1'b0 :
              bcfg_reg[area[1:0]][`EMAC_BIT_RECOV])) begin
            state_next = EMAC_RECOV;
          end else begin
            state_next = EMAC_CYC;
          end
        end
      end
      EMAC_RECOV: begin
        state_next = EMAC_CYC;
      end
      EMAC_CYC: begin
        cnt_next = 3'(cnt_reg + 3'h1);
        if (pin_mode && !page_ok) begin
          if (cnt_reg >= 3'h2 && !wait_busy) begin
            state_next = EMAC_DONE;
          end
          if (cnt_reg == 3'h7) begin
            cnt_next = 3'h7;
          end
        end else if (cnt_reg >= len) begin
          state_next = EMAC_DONE;
        end
      end
      EMAC_DONE: begin
        last_area_next = area;
        // A full read in area 2 opens the page; crossing a page closes it.
        in_page_next  = page_reg[`EMAC_BIT_PG_EN] &&
                        area == 3'h2 && !mem_we;
        page_tag_next = mem_addr[23:3];
        state_next = EMAC_HOLD;
      end
      EMAC_HOLD: begin
        if (!mem_req) begin
          state_next = EMAC_IDLE;
        end
      end
      default: state_next = EMAC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= EMAC_IDLE;
      cnt_reg       <= 3'h0;
      last_area_reg <= 3'h4;
      in_page_reg   <= 1'b0;
      page_tag_reg  <= 21'h0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      last_area_reg <= last_area_next;
      in_page_reg   <= in_page_next;
      page_tag_reg  <= page_tag_next;
    end
  end

  // Outputs toward the memory side.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chip_sel_n[i] = !(state_reg == EMAC_CYC && hit[i] && area == 3'(i));
    end
  end
  assign strobe_n   = state_reg != EMAC_CYC;
  assign mem_ack    = state_reg == EMAC_DONE;
  assign bus_width  = cur_bus[1:0];
  assign mem_type   = cur_bus[3:2];
  assign page_cycle = state_reg == EMAC_CYC && page_ok;

  // Checks.
  // A pin-wait cycle never ends after its first state.
  property p_pin_min;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == EMAC_CYC && pin_mode && !page_ok && cnt_reg == 3'h1)
        |=> state_reg == EMAC_CYC;
  endproperty
  a_pin_min: assert property (p_pin_min) else $error("too short");

  property p_pin_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == EMAC_CYC && pin_mode && !page_ok && wait_busy)
        |=> !mem_ack;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("no wait");

  property p_page_only2;
    @(posedge clk) disable iff (!rst_n)
      page_cycle |-> area == 3'h2 && page_reg[`EMAC_BIT_PG_EN];
  endproperty
  a_page_only2: assert property (p_page_only2) else $error("page");

  property p_recov;
    @(posedge clk) disable iff (!rst_n)
      state_reg == EMAC_RECOV |=> state_reg == EMAC_CYC && strobe_n == 1'b0;
  endproperty
  a_recov: assert property (p_recov) else $error("recovery len");

  property p_cs_en;
    @(posedge clk) disable iff (!rst_n)
      !chip_sel_n[1] |-> bcfg_reg[1][`EMAC_BIT_ENABLE];
  endproperty
  a_cs_en: assert property (p_cs_en) else $error("cs gated");

  property p_sdram;
    @(posedge clk) disable iff (!rst_n)
      bcfg_reg[0][3:2] != `EMAC_MT_SDRAM;
  endproperty
  a_sdram: assert property (p_sdram) else $error("sdram in area0");

  property p_default;
    @(posedge clk) disable iff (!rst_n)
      hit == 4'h0 |-> bus_width == dbus_reg[1:0];
  endproperty
  a_default: assert property (p_default) else $error("default width");

  property p_prio;
    @(posedge clk) disable iff (!rst_n)
      hit[0] |-> area == 3'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("priority");

endmodule

/* emac_mem_model.sv */
// Model of the external memory that answers on the wait pin.
`timescale 1ns/100ps
module emac_mem_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] chip_sel_n,
  input  wire logic       strobe_n,
  input  wire logic [7:0] stall_len,
  output logic            wait_n
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       stall;

  // Counts bus states since the strobe fell, restarting between cycles.
  always_comb begin
    cnt_next = strobe_n ? 8'h00 : cnt_reg + 8'h01;
  end

  // Registers the state count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // The pin has a pull-up, so it rests high unless a stall is asked for.
  assign stall = !strobe_n && (chip_sel_n != 4'hF) && (cnt_reg < stall_len);
  assign wait_n = !stall;
endmodule

/* emac_pkg.sv */
// Types shared by the area controller.
package emac_pkg;
  typedef enum logic [4:0] {
    EMAC_IDLE  = 5'h01,
    EMAC_RECOV = 5'h02,
    EMAC_CYC   = 5'h04,
    EMAC_DONE  = 5'h08,
    EMAC_HOLD  = 5'h10
  } emac_state_t;
endpackage

/* emac_regs.svh */
// Register offsets, field positions and reset values of the area controller.
`ifndef EMAC_REGS_SVH
`define EMAC_REGS_SVH
`define EMAC_OFS_A0_WAIT   8'h00
`define EMAC_OFS_A0_BUS    8'h01
`define EMAC_OFS_A0_MASK   8'h02
`define EMAC_OFS_A0_START  8'h03
`define EMAC_OFS_PAGE      8'h20
`define EMAC_OFS_DEF_WAIT  8'h18
`define EMAC_OFS_DEF_BUS   8'h19
`define EMAC_OFS_STATUS    8'h21
`define EMAC_AREA_STRIDE   8'h04
`define EMAC_WAIT_RST      8'h22
`define EMAC_BUS_RST       8'h00
`define EMAC_A2_BUS_RST    8'h80
`define EMAC_MASK_RST      8'hFF
`define EMAC_START_RST     8'hFF
`define EMAC_PAGE_RST      8'h02
`define EMAC_WS_2          3'h1
`define EMAC_WS_3          3'h2
`define EMAC_WS_4          3'h5
`define EMAC_WS_5          3'h6
`define EMAC_WS_6          3'h7
`define EMAC_WS_PIN        3'h3
`define EMAC_MT_SDRAM      2'h3
`define EMAC_BIT_ENABLE    7
`define EMAC_BIT_RANGE     6
`define EMAC_BIT_RECOV     4
`define EMAC_BIT_PG_EN     4
`endif

/* external_memory_area_controller_tb.sv */
// Self-checking bench for the area controller.
`timescale 1ns/100ps
module external_memory_area_controller_tb;
  import emac_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, mem_req = 1'b0, mem_we = 1'b0, mem_ack;
  logic [7:0] wb_adr_i = 8'h00, stall_len = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, cs_s, bw_s, pg_s, mt_s;
  logic [3:0] wb_sel_i = 4'h1, chip_sel_n;
  logic [23:0] mem_addr = 24'h0;
  logic [1:0] boot_width_pins = 2'h1, bus_width, mem_type;
  logic wait_n, strobe_n, page_cycle;
  int err_total = 0, samples_checked = 0, st, pre, p1;
  localparam logic [7:0] PG_PR [17] = '{8'h13, 8'h13, 8'h13, 8'h17, 8'h17,
    8'h1B, 8'h1B, 8'h1B, 8'h12, 8'h12, 8'h12, 8'h10, 8'h10, 8'h10,
    8'h11, 8'h11, 8'h11};
  localparam logic [23:0] PG_AD [17] = '{24'h400, 24'h401, 24'h408,
    24'h410, 24'h411, 24'h420, 24'h421, 24'h428, 24'h500, 24'h508,
    24'h510, 24'h600, 24'h63F, 24'h640, 24'h700, 24'h71F, 24'h720};
  localparam int PG_EX [17] = '{6, 1, 6, 6, 2, 6, 3, 6, 6, 1, 6, 6, 1, 6,
    6, 1, 6};

  emac_ctrl i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .wait_n(wait_n),
    .boot_width_pins(boot_width_pins), .chip_sel_n(chip_sel_n),
    .bus_width(bus_width), .mem_type(mem_type), .strobe_n(strobe_n),
    .page_cycle(page_cycle));
  emac_mem_model i_mem (.clk(clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n),
    .strobe_n(strobe_n), .stall_len(stall_len), .wait_n(wait_n));

  // Free-running 50 MHz clock.
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("wrong value at %0t: no answer", $time);
    finish_test();
  endtask

  // Classic single Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 50) hang();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask

  // One access; counts idle states before the strobe and strobe states.
  task automatic acc(input logic [23:0] a, input logic w);
    int n;
    st = 0;
    pre = 0;
    mem_addr <= a;
    mem_we <= w;
    mem_req <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (mem_ack === 1'b1) break;
      if (strobe_n === 1'b0) begin
        if (st == 0) begin
          cs_s = {28'h0, chip_sel_n};
          bw_s = {30'h0, bus_width};
          mt_s = {30'h0, mem_type};
          pg_s = {31'h0, page_cycle};
        end
        st++;
      end else if (st == 0) begin
        pre++;
      end
    end
    if (n == 200) hang();
    mem_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    rd(8'h20, 8'h02);
    rd(8'h03, 8'hFF);
    rd(8'h02, 8'hFF);
    rd(8'h0A, 8'hFF);
    rd(8'h00, 8'h00);
    wr(8'h30, 8'h5A);
    rd(8'h30, 8'h00);
    acc(24'h000100, 1'b0);
    check(st, 3);
    check(bw_s, 1);
    check(cs_s, 4'hB);
    check(pg_s, 0);
    $display("reset test done");
  endtask

  task automatic t_waits();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++) begin
      wr(8'h08, {1'b0, c[i], 1'b0, c[i]});
      acc(24'h000100, 1'b0);
      check(st, i + 2);
      acc(24'h000100, 1'b1);
      check(st, i + 2);
    end
    $display("wait test done");
  endtask

  task automatic t_pin();
    int s0;
    wr(8'h08, 8'h33);
    acc(24'h000100, 1'b0);
    s0 = st;
    check(s0, 2);
    stall_len <= 8'h06;
    acc(24'h000100, 1'b1);
    check(st, 7);
    check(st > s0, 1);
    stall_len <= 8'h00;
    $display("pin test done");
  endtask

  task automatic t_page();
    wr(8'h08, 8'h77);
    for (int i = 0; i < 17; i++) begin
      wr(8'h20, PG_PR[i]);
      acc(PG_AD[i], 1'b0);
      check(st, PG_EX[i]);
      check(pg_s, PG_EX[i] != 6);
    end
    $display("page test done");
  endtask

  task automatic t_area();
    wr(8'h03, 8'hE0);
    rd(8'h03, 8'hE0);
    wr(8'h01, 8'h92);
    wr(8'h07, 8'hC0);
    wr(8'h05, 8'h8C);
    acc(24'h000100, 1'b0);
    acc(24'hE00000, 1'b0);
    p1 = pre;
    check(cs_s, 4'hE);
    check(bw_s, 2);
    acc(24'hE00001, 1'b0);
    check(p1, pre + 1);
    check(st, 3);
    check(pg_s, 0);
    acc(24'hC00000, 1'b0);
    check(cs_s, 4'hD);
    check(mt_s, 3);
    $display("area test done");
  endtask

  task automatic t_default();
    wr(8'h09, 8'h00);
    wr(8'h18, 8'h07);
    wr(8'h19, 8'h02);
    acc(24'h000200, 1'b0);
    check(st, 6);
    check(bw_s, 2);
    check(cs_s, 4'hF);
    wr(8'h0B, 8'h10);
    wr(8'h0A, 8'h00);
    wr(8'h09, 8'hC1);
    acc(24'h100000, 1'b0);
    check(cs_s, 4'hB);
    check(bw_s, 1);
    acc(24'h000200, 1'b0);
    check(cs_s, 4'hF);
    $display("default test done");
  endtask

  // Reset for 20 cycles, then each scenario in turn.
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_waits();
    t_pin();
    t_page();
    t_area();
    t_default();
    finish_test();
  end
endmodule
